/* File: logic/serial_dma_bus_master.sv */
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module serial_dma_bus_master #(
    parameter logic [13:0] RX_MASK = 14'h1555
) (
    input  wire logic                                                 i_clk,
    input  wire logic                                                 i_nrst,
    input  wire logic [serial_dma_pkg::NUM_CHAN-1:0]                  i_chan_req,
    input  wire logic [serial_dma_pkg::NUM_CHAN*serial_dma_pkg::ADDR_W-1:0] i_chan_addr,
    input  wire logic [serial_dma_pkg::NUM_CHAN*serial_dma_pkg::DATA_W-1:0] i_chan_wdata,
    input  wire logic [serial_dma_pkg::NUM_CHAN*2-1:0]                i_chan_size,
    input  wire logic [serial_dma_pkg::NUM_CHAN*serial_dma_pkg::FC_W-1:0]   i_chan_fc,
    input  wire logic [serial_dma_pkg::NUM_CHAN-1:0]                  i_chan_le,
    input  wire logic [serial_dma_pkg::NUM_CHAN-1:0]                  i_chan_ext,
    output logic      [serial_dma_pkg::NUM_CHAN-1:0]                  o_chan_done,
    output logic      [serial_dma_pkg::DATA_W-1:0]                    o_chan_rdata,
    output logic                                                      o_int_req,
    output logic                                                      o_ext_req,
    output logic      [serial_dma_pkg::ID_W-1:0]                      o_arb_id,
    input  wire logic                                                 i_bus_grant,
    input  wire logic                                                 i_other_req,
    input  wire logic [serial_dma_pkg::ID_W-1:0]                      i_other_id,
    input  wire logic                                                 i_master_mode,
    input  wire logic                                                 i_show_cycles,
    output logic                                                      o_cyc,
    output logic                                                      o_ext_visible,
    output logic                                                      o_we,
    output logic      [serial_dma_pkg::ADDR_W-1:0]                    o_addr,
    output logic      [serial_dma_pkg::DATA_W-1:0]                    o_wdata,
    output logic      [1:0]                                           o_size,
    output logic      [serial_dma_pkg::FC_W-1:0]                      o_fc,
    input  wire logic [serial_dma_pkg::DATA_W-1:0]                    i_rdata,
    input  wire logic [1:0]                                           i_port_size,
    input  wire logic                                                 i_cyc_ack,
    input  wire logic                                                 i_bus_err,
    input  wire logic [2:0]                                           i_service_level,
    input  wire logic                                                 i_freeze,
    input  wire logic                                                 i_bclr_pin_en,
    output logic                                                      o_bus_clear,
    output logic                                                      o_halted,
    input  wire logic [3:0]                                           i_reg_addr,
    input  wire logic [31:0]                                          i_reg_wdata,
    input  wire logic                                                 i_reg_wr,
    input  wire logic                                                 i_reg_rd,
    output logic      [31:0]                                          o_reg_rdata
);
    import serial_dma_pkg::*;

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        state_type              state;
        logic [CHAN_BITS-1:0]   chan;
        logic [ADDR_W-1:0]      addr;
        logic [DATA_W-1:0]      data;
        logic [2:0]             rem;
        logic [1:0]             size;
        logic                   we;
        logic                   le;
        logic                   ext;
        logic [FC_W-1:0]        fc;
        logic [15:0]            config_reg;
        logic                   bclr_en;
        logic [ID_W-1:0]        bclr_thr;
        logic                   berr;
        logic [ADDR_W-1:0]      err_addr;
        logic [NUM_CHAN-1:0]    done;
        logic [DATA_W-1:0]      rdata_out;
        logic                   bclr;
        logic [31:0]            reg_rdata;
        logic                   int_req;
        logic                   ext_req;
        logic                   cyc;
        logic                   vis;
        logic                   halted;
        logic [ID_W-1:0]        arb_id;
    } regs_type;

    regs_type r;
    regs_type next_r;

    // ****************************************
    // Per-channel descriptor unpacking
    // ****************************************
    logic [ADDR_W-1:0] ch_addr  [NUM_CHAN];
    logic [DATA_W-1:0] ch_wdata [NUM_CHAN];
    logic [1:0]        ch_size  [NUM_CHAN];
    logic [FC_W-1:0]   ch_fc    [NUM_CHAN];

    // Each channel has its own fixed direction and code
    genvar g;
    generate
        for (g = 0; g < NUM_CHAN; g++) begin : g_chan
            assign ch_addr[g]  = i_chan_addr[g*ADDR_W +: ADDR_W];
            assign ch_wdata[g] = i_chan_wdata[g*DATA_W +: DATA_W];
            assign ch_size[g]  = i_chan_size[g*2 +: 2];
            assign ch_fc[g]    = i_chan_fc[g*FC_W +: FC_W];
        end
    endgenerate

    // ****************************************
    // Helpers
    // ****************************************
    // Swap byte lanes for little-endian channels
    function automatic logic [31:0] swap32(input logic [31:0] d);
        swap32 = {d[7:0], d[15:8], d[23:16], d[31:24]};
    endfunction

    // Bytes carried by one cycle of the current port
    function automatic logic [2:0] port_bytes(input logic [1:0] ps);
        unique case (ps)
            PORT_16: port_bytes = 3'h2;
            PORT_8:  port_bytes = 3'h1;
            default: port_bytes = 3'h4;
        endcase
    endfunction

    // ****************************************
    // Combinational terms
    // ****************************************
    logic [ID_W-1:0] own_id;
    logic [2:0]      svc_mask;
    logic [1:0]      frz_sel;
    logic            frozen;
    logic            masked;
    logic            preempt;
    logic            blocked;
    logic            any_req;
    logic [CHAN_BITS-1:0] pick;
    logic [2:0]      nbytes;
    logic [5:0]      nbits;
    logic [31:0]     piece;
    logic [31:0]     acc;
    logic [2:0]      rem_after;

    // Fields of the shared configuration word
    assign own_id   = r.arb_id;
    assign svc_mask = r.config_reg[MASK_LSB +: 3];
    assign frz_sel  = r.config_reg[FRZ_LSB +: 2];
    assign frozen   = (frz_sel == FRZ_STOP) && i_freeze;
    assign masked   = i_service_level > svc_mask;
    // Higher ID wins; seven is top, zero bottom
    assign preempt  = i_other_req && (i_other_id > own_id);
    // Freeze or service mask holds the request low
    assign blocked  = frozen || masked;
    assign any_req = |i_chan_req;

    // Lowest-numbered requesting channel wins among the pool
    always_comb begin
        pick = '0;
        for (int k = NUM_CHAN - 1; k >= 0; k--) begin
            if (i_chan_req[k]) begin
                pick = CHAN_BITS'(k);
            end
        end
    end

    // Split the operand over narrow ports, most significant lanes first
    always_comb begin
        nbytes    = (port_bytes(i_port_size) < r.rem) ? port_bytes(i_port_size) : r.rem;
        nbits     = {nbytes, 3'h0};
        piece     = i_rdata >> (6'd32 - nbits);
        acc       = (nbytes == 3'h4) ? piece : ((r.data << nbits) | piece);
        rem_after = r.rem - nbytes;
    end

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        next_r      = r;
        next_r.done = '0;

        // Status bit clears on a one; hardware set below wins
        if (i_reg_wr && i_reg_addr == STATUS_OFS && i_reg_wdata[BERR_BIT]) begin
            next_r.berr = 1'b0;
        end
        // Config write keeps only the defined fields
        if (i_reg_wr && i_reg_addr == CONFIG_OFS) begin
            next_r.config_reg = i_reg_wdata[15:0] & 16'h6770;
        end
        // Module config: bus clear enable and threshold
        if (i_reg_wr && i_reg_addr == MODCFG_OFS) begin
            next_r.bclr_en  = i_reg_wdata[BCLR_EN_BIT];
            next_r.bclr_thr = i_reg_wdata[THR_LSB +: ID_W];
        end

        // Read data stands one cycle after the strobe
        next_r.reg_rdata = '0;
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                CONFIG_OFS: next_r.reg_rdata = {16'h0000, r.config_reg};
                STATUS_OFS: next_r.reg_rdata = {30'h0, r.berr, 1'b0};
                ERRADR_OFS: next_r.reg_rdata = r.err_addr;
                MODCFG_OFS: next_r.reg_rdata = {23'h0, r.state == ST_HALT, 1'b0, r.bclr_thr, 3'h0, r.bclr_en};
                default:    next_r.reg_rdata = '0;
            endcase
        end

        unique case (r.state)
            ST_IDLE: begin
                // Latch the winning channel's descriptor
                if (any_req && !blocked) begin
                    next_r.chan  = pick;
                    next_r.addr  = ch_addr[pick];
                    next_r.we    = RX_MASK[pick];
                    next_r.le    = i_chan_le[pick];
                    next_r.ext   = i_chan_ext[pick];
                    next_r.fc    = ch_fc[pick];
                    // Receive writes only the characters it holds
                    next_r.size  = RX_MASK[pick] ? ch_size[pick] : SZ_LONG;
                    unique case (next_r.size)
                        SZ_BYTE: next_r.rem = 3'h1;
                        SZ_WORD: next_r.rem = 3'h2;
                        default: next_r.rem = 3'h4;
                    endcase
                    // Operand sits in the top lanes; only long operands are swapped for little endian
                    next_r.data  = (i_chan_le[pick] ? swap32(ch_wdata[pick]) : ch_wdata[pick])
                                   << (6'd32 - {next_r.rem, 3'h0});
                    if (i_chan_le[pick] && next_r.size != SZ_LONG) begin
                        next_r.data = ch_wdata[pick] << (6'd32 - {next_r.rem, 3'h0});
                    end
                    // Request goes out in the next cycle
                    next_r.state = ST_REQ;
                end
            end
            ST_REQ: begin
                // Grant comes from the shared arbiter; zero overhead when free
                if (blocked || preempt) begin
                    next_r.state = ST_YIELD;
                end else if (i_bus_grant) begin
                    next_r.state = ST_XFER;
                end
            end
            ST_XFER: begin
                // Error ends the operand and stops every channel
                if (i_bus_err) begin
                    next_r.berr     = 1'b1;
                    next_r.err_addr = r.addr;
                    next_r.state    = ST_HALT;
                end else if (i_cyc_ack) begin
                    // Advance by the bytes this cycle carried
                    next_r.addr = r.addr + {29'h0, nbytes};
                    next_r.rem  = rem_after;
                    next_r.data = r.we ? (r.data << nbits) : acc;
                    if (rem_after == 3'h0) begin
                        // One operand per tenure, then release
                        next_r.done[r.chan] = 1'b1;
                        next_r.rdata_out    = r.le ? swap32(acc) : acc;
                        next_r.state        = ST_IDLE;
                    end else if (preempt || blocked) begin
                        next_r.state = ST_YIELD;
                    end
                end
            end
            ST_YIELD: begin
                // Request dropped until the bus is ours to contest again
                if (!preempt && !blocked) begin
                    next_r.state = ST_REQ;
                end
            end
            ST_HALT: begin
                // Only a processor reset brings the channels back
                if (i_reg_wr && i_reg_addr == MODCFG_OFS && i_reg_wdata[CPRST_BIT]) begin
                    next_r.state = ST_IDLE;
                end
            end
            default: next_r.state = ST_IDLE;
        endcase

        // Bus clear: asserted while requesting, negated while accessing
        next_r.bclr = r.bclr_en && i_bclr_pin_en && (own_id > r.bclr_thr)
                      && (next_r.state == ST_REQ);

        // Slave mode forces the top ID; otherwise the programmed one
        next_r.arb_id  = i_master_mode ? next_r.config_reg[SAID_LSB +: ID_W] : {ID_W{1'b1}};
        // Output flags follow the next state, so each comes from a flop
        next_r.int_req = (next_r.state == ST_REQ) || (next_r.state == ST_XFER);
        next_r.ext_req = next_r.int_req && next_r.ext;
        next_r.cyc     = next_r.state == ST_XFER;
        next_r.vis     = next_r.cyc && (next_r.ext || i_show_cycles);
        next_r.halted  = next_r.state == ST_HALT;
    end

    // ****************************************
    // State register
    // ****************************************
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            r            <= '0;
            r.state      <= ST_IDLE;
            r.config_reg <= CONFIG_RST;
        end else begin
            r            <= next_r;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Requests go to the internal arbiter; the external request is also raised for ext channels
    assign o_int_req     = r.int_req;
    assign o_ext_req     = r.ext_req;
    assign o_arb_id      = r.arb_id;
    assign o_cyc         = r.cyc;
    assign o_ext_visible = r.vis;

    // Bus cycle fields and status
    assign o_we          = r.we;
    assign o_addr        = r.addr;
    assign o_wdata       = r.data;
    assign o_size        = r.size;
    assign o_fc          = r.fc;
    assign o_chan_done   = r.done;
    assign o_chan_rdata  = r.rdata_out;
    assign o_bus_clear   = r.bclr;
    assign o_halted      = r.halted;
    assign o_reg_rdata   = r.reg_rdata;

endmodule

/* File: logic/serial_dma_pkg.sv */
package serial_dma_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_CHAN  = 14;
    localparam int CHAN_BITS = 4;
    localparam int ADDR_W    = 32;
    localparam int DATA_W    = 32;
    localparam int FC_W      = 4;
    localparam int ID_W      = 3;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [3:0] CONFIG_OFS = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] ERRADR_OFS = 4'h8;
    localparam logic [3:0] MODCFG_OFS = 4'hC;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int FRZ_LSB     = 13;
    localparam int MASK_LSB    = 8;
    localparam int SAID_LSB    = 4;
    localparam int BERR_BIT    = 1;
    localparam int BCLR_EN_BIT = 0;
    localparam int THR_LSB     = 4;
    localparam int CPRST_BIT   = 8;
    localparam logic [15:0] CONFIG_RST = 16'h0000;
    localparam logic [1:0] FRZ_STOP    = 2'h2;

    // ****************************************
    // Operand sizes and port widths
    // ****************************************
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [1:0] PORT_32 = 2'h0;
    localparam logic [1:0] PORT_16 = 2'h1;
    localparam logic [1:0] PORT_8  = 2'h2;

    // ****************************************
    // Sequencer states, Gray from idle through request to transfer
    // ****************************************
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_REQ   = 3'h1,
        ST_XFER  = 3'h3,
        ST_YIELD = 3'h2,
        ST_HALT  = 3'h6
    } state_type;

endpackage

/* File: testbench/serial_dma_channel_props.sv */
`timescale 1ns/1ps
// ****************
// Bus master checker
// ****************
module bus_master_props (
    input wire logic                                i_clk,
    input wire logic                                i_nrst,
    input wire logic [serial_dma_pkg::NUM_CHAN-1:0] o_chan_done,
    input wire logic                                o_int_req,
    input wire logic                                o_ext_req,
    input wire logic [serial_dma_pkg::ID_W-1:0]     o_arb_id,
    input wire logic                                i_other_req,
    input wire logic [serial_dma_pkg::ID_W-1:0]     i_other_id,
    input wire logic                                i_master_mode,
    input wire logic                                o_cyc,
    input wire logic                                o_ext_visible,
    input wire logic                                i_cyc_ack,
    input wire logic                                i_bus_err,
    input wire logic                                i_bclr_pin_en,
    input wire logic                                o_bus_clear,
    input wire logic                                o_halted,
    input wire logic [3:0]                          i_reg_addr,
    input wire logic                                i_reg_wr
);
    import serial_dma_pkg::*;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    // Bus ownership and release
    ext_req_nest_a: assert property (o_ext_req |-> o_int_req) else $error("external request alone");
    vis_cycle_a: assert property (o_ext_visible |-> o_cyc) else $error("visible without cycle");
    done_single_a: assert property ($onehot0(o_chan_done)) else $error("two channels done");
    done_release_a: assert property (|o_chan_done |-> !o_cyc) else $error("bus held after done");
    done_gap_a: assert property (|o_chan_done |=> !(|o_chan_done) [*2]) else $error("done too soon");
    preempt_yield_a: assert property (o_cyc && i_cyc_ack && i_other_req && i_other_id > o_arb_id |=> !o_cyc)
        else $error("bus kept against higher master");
    id_hold_a: assert property (!i_reg_wr && $stable(i_master_mode) |=> $stable(o_arb_id))
        else $error("id moved");
    // Bus clear output
    bclr_access_a: assert property (o_bus_clear |-> !o_cyc) else $error("bus clear during access");
    bclr_id_a: assert property (o_bus_clear |-> o_arb_id != 3'h0 && $past(i_bclr_pin_en))
        else $error("bus clear not allowed");
    // Bus error halt
    halt_quiet_a: assert property (o_halted |-> !o_int_req && !o_cyc) else $error("activity in halt");
    berr_halt_a: assert property (o_cyc && i_bus_err |=> o_halted) else $error("no halt on error");
    halt_hold_a: assert property (o_halted && !(i_reg_wr && i_reg_addr == MODCFG_OFS) |=> o_halted)
        else $error("halt left alone");

    cover property (|o_chan_done);
    cover property (o_halted);
    cover property (o_bus_clear);
    cover property (o_cyc && i_cyc_ack && i_other_req);
endmodule

bind serial_dma_bus_master bus_master_props u_props (.*);

/* File: testbench/bus_partner.sv */
`timescale 1ns/1ps
// ****************
// Memory and bus owner
// ****************
module bus_partner (
    input  wire logic        i_clk,
    input  wire logic        i_req,
    input  wire logic        i_cyc,
    input  wire logic [31:0] i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic [7:0]  i_tag,
    input  wire logic        i_err_en,
    input  wire logic [1:0]  i_wait,
    output logic             o_grant,
    output logic             o_ack,
    output logic             o_err,
    output logic [31:0]      o_rdata
);
    logic [1:0]  wcnt = 2'h0;
    logic [31:0] log_addr [8];
    logic [31:0] log_data [8];
    logic [7:0]  log_tag  [8];
    int          n = 0;

    function automatic logic [7:0] mem_byte(input logic [31:0] a);
        return a[7:0] + 8'h11;
    endfunction

    // Grant trails request; cycle ends after chosen wait
    always @(posedge i_clk) begin
        o_grant <= i_req;
        o_ack <= 1'b0;
        o_err <= 1'b0;
        o_rdata <= ~o_rdata;  // No stale data between cycles
        if (i_cyc && !o_ack && !o_err) begin
            wcnt <= wcnt + 2'h1;
            if (wcnt == i_wait) begin
                wcnt <= 2'h0;
                o_ack <= !i_err_en;
                o_err <= i_err_en;
                o_rdata <= {mem_byte(i_addr), mem_byte(i_addr + 1), mem_byte(i_addr + 2), mem_byte(i_addr + 3)};
                log_addr[n % 8] <= i_addr;
                log_data[n % 8] <= i_wdata;
                log_tag[n % 8] <= i_tag;
                n <= n + 1;
            end
        end
    end
    initial o_rdata = 32'h0;
endmodule

/* File: testbench/serial_dma_bus_master_tb.sv */
`timescale 1ns/1ps
module serial_dma_bus_master_tb;
    import serial_dma_pkg::*;
    logic i_clk, i_nrst, i_bus_grant, i_other_req, i_master_mode, i_show_cycles, i_cyc_ack, i_bus_err, i_freeze;
    logic i_bclr_pin_en, i_reg_wr, i_reg_rd, o_int_req, o_ext_req, o_cyc, o_ext_visible, o_we, o_bus_clear, o_halted;
    logic [NUM_CHAN-1:0]   i_chan_req, req_q, i_chan_le, i_chan_ext, o_chan_done;
    logic [NUM_CHAN*32-1:0] i_chan_addr, i_chan_wdata;
    logic [NUM_CHAN*2-1:0] i_chan_size;
    logic [NUM_CHAN*4-1:0] i_chan_fc;
    logic [31:0]           o_chan_rdata, o_addr, o_wdata, i_rdata, i_reg_wdata, o_reg_rdata;
    logic [2:0]            o_arb_id, i_other_id, i_service_level;
    logic [1:0]            o_size, i_port_size, wait_n;
    logic [3:0]            o_fc, i_reg_addr;
    logic                  err_en, seen_bclr, seen_ext;
    int                    failures, checks_done, base, k;

    serial_dma_bus_master DUT (.*);
    bus_partner mem (.i_clk(i_clk), .i_req(o_int_req), .i_cyc(o_cyc), .i_addr(o_addr), .i_wdata(o_wdata),
        .i_tag({o_we, o_ext_visible, o_size, o_fc}), .i_err_en(err_en), .i_wait(wait_n),
        .o_grant(i_bus_grant), .o_ack(i_cyc_ack), .o_err(i_bus_err), .o_rdata(i_rdata));

    // Channel lets go as soon as done shows
    assign i_chan_req = req_q & ~o_chan_done;
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Outside logic would hold a cleared master off the bus; here it only latches
    always @(posedge i_clk) if (o_bus_clear) seen_bclr <= 1'b1;
    always @(posedge i_clk) if (o_ext_req) seen_ext <= 1'b1;

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task reg_wr(input logic [3:0] a, input logic [31:0] d);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
        @(posedge i_clk);
    endtask
    task reg_rd(input logic [3:0] a, input logic [31:0] exp, input string name);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_clk);
        check(name, o_reg_rdata, exp);
    endtask
    task xfer(input int ch, input logic [31:0] exp_rd, input int pieces, input string name);
        k = 0;
        base = mem.n;
        req_q[ch] <= 1'b1;
        do @(posedge i_clk); while (!o_chan_done[ch] && ++k < 100);
        req_q[ch] <= 1'b0;
        check(name, o_chan_done[ch], 32'h1);
        check(name, mem.n - base, pieces);
        if (ch % 2 == 1) check(name, o_chan_rdata, exp_rd);
        // Let an edge pass so a following call does not reassign the request
        @(posedge i_clk);
    endtask
    task stall(input int ch, input string name);
        req_q[ch] <= 1'b1;
        repeat (6) begin
            @(posedge i_clk);
            check(name, o_int_req, 32'h0);
        end
    endtask
    task results;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        {i_nrst, req_q, i_chan_le, i_other_req, i_other_id, i_show_cycles, i_freeze, i_reg_wr, i_reg_rd} = '0;
        {i_reg_addr, i_reg_wdata, i_service_level, wait_n, err_en, seen_bclr, seen_ext, failures, checks_done} = '0;
        {i_chan_ext, i_master_mode, i_bclr_pin_en, i_port_size} = {{NUM_CHAN{1'b1}}, 2'h3, PORT_32};
        for (int c = 0; c < NUM_CHAN; c++) begin
            i_chan_addr[c*32+:32] = 32'h100 * c;
            i_chan_wdata[c*32+:32] = 32'hA1B2C3D4;
            i_chan_size[c*2+:2] = SZ_LONG;
            i_chan_fc[c*4+:4] = 4'(c + 1);
        end
        repeat (8) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        reg_rd(CONFIG_OFS, 32'h0, "config reset");
        reg_wr(CONFIG_OFS, 32'h0740);
        reg_rd(CONFIG_OFS, 32'h0740, "config");
        check("arb id", o_arb_id, 32'h4);
        i_master_mode <= 1'b0;
        repeat (2) @(posedge i_clk);
        check("slave id", o_arb_id, 32'h7);
        i_master_mode <= 1'b1;
        reg_rd(4'h2, 32'h0, "unmapped");
        reg_wr(MODCFG_OFS, 32'h31);
        xfer(0, 0, 1, "long write");
        check("bclr on", seen_bclr, 32'h1);
        check("long data", mem.log_data[base], 32'hA1B2C3D4);
        check("long tag", mem.log_tag[base], 32'hE1);
        check("ext req on", seen_ext, 32'h1);
        reg_wr(MODCFG_OFS, 32'h41);
        seen_bclr <= 1'b0;
        seen_ext <= 1'b0;
        i_chan_ext[2] <= 1'b0;
        i_chan_size[4+:2] <= SZ_WORD;
        i_port_size <= PORT_16;
        xfer(2, 0, 1, "word write");
        check("bclr off", seen_bclr, 32'h0);
        check("word data", mem.log_data[base][31:16], 32'hC3D4);
        check("word tag", mem.log_tag[base], 32'h93);
        i_show_cycles <= 1'b1;
        i_chan_size[4+:2] <= SZ_BYTE;
        xfer(2, 0, 1, "byte write");
        check("byte data", mem.log_data[base % 8][31:24], 32'hD4);
        check("byte tag", mem.log_tag[base % 8], 32'hC3);
        check("ext req off", seen_ext, 32'h0);
        i_port_size <= PORT_8;
        xfer(1, 32'h11121314, 4, "read be");
        check("last addr", mem.log_addr[(base + 3) % 8], 32'h103);
        i_chan_le[1] <= 1'b1;
        xfer(1, 32'h14131211, 4, "read le");
        i_port_size <= PORT_16;
        i_other_id <= 3'h5;
        fork
            xfer(0, 0, 2, "preempt");
            begin
                do @(posedge i_clk); while (!o_cyc);
                i_other_req <= 1'b1;
                repeat (5) @(posedge i_clk);
                check("yield", mem.n - base, 32'h1);
                i_other_req <= 1'b0;
            end
        join
        check("resume addr", mem.log_addr[(base + 1) % 8], 32'h2);
        reg_wr(CONFIG_OFS, 32'h4340);
        i_freeze <= 1'b1;
        stall(3, "freeze");
        i_freeze <= 1'b0;
        i_service_level <= 3'h5;
        stall(3, "mask");
        i_service_level <= 3'h3;
        xfer(3, 32'h11121314, 2, "unmasked");
        reg_wr(CONFIG_OFS, 32'h0740);
        i_freeze <= 1'b1;
        xfer(5, 32'h11121314, 2, "freeze ignored");
        i_freeze <= 1'b0;
        err_en <= 1'b1;
        req_q[6] <= 1'b1;
        k = 0;
        do @(posedge i_clk); while (!o_halted && ++k < 50);
        req_q[6] <= 1'b0;
        err_en <= 1'b0;
        check("halted", o_halted, 32'h1);
        reg_rd(STATUS_OFS, 32'h2, "status");
        reg_rd(ERRADR_OFS, 32'h600, "err addr");
        reg_wr(STATUS_OFS, 32'h0);
        reg_rd(STATUS_OFS, 32'h2, "status kept");
        reg_wr(STATUS_OFS, 32'h2);
        reg_rd(STATUS_OFS, 32'h0, "status cleared");
        reg_rd(MODCFG_OFS, 32'h141, "halt flag");
        reg_wr(MODCFG_OFS, 32'h141);
        check("restart", o_halted, 32'h0);
        results;
    end

    // Watchdog
    initial begin
        #(25 * 3000);
        failures++;
        results;
    end
endmodule
